//--- colour_exposure_csr.sv
// The AXI4-Lite interface to the registers was chosen for this implementation.
`default_nettype none
module colour_exposure_csr
  import colour_exposure_pkg::*;
#(
  parameter bit COLOUR_VARIANT = 1'b1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic [LEVEL_W-1:0] blue_level,
  output logic [LEVEL_W-1:0] red_level,
  output logic [LEVEL_W-1:0] exposure_count,
  input wire logic exposure_start,
  output logic exposure_active
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic reg_sel_type decode_sel(input logic [ADDR_W-1:0] a);
    if (a[ADDR_W-1:2] == COLOUR_BALANCE_CONTROL_OFFSET[ADDR_W-1:2]) begin
      return SEL_COLOUR;
    end else if (a[ADDR_W-1:2] == EXPOSURE_CONTROL_OFFSET[ADDR_W-1:2]) begin
      return SEL_EXPOSURE;
    end
    return SEL_NONE;
  endfunction

  function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old,
      input logic [DATA_W-1:0] data, input logic [STRB_W-1:0] strb);
    logic [DATA_W-1:0] res;
    res = old;
    for (int i = 0; i < STRB_W; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic level_ok(input logic [LEVEL_W-1:0] v);
    return (v >= LEVEL_MIN) && (v <= LEVEL_MAX);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [LEVEL_W-1:0] blue_q, blue_d, red_q, red_d, exp_q, exp_d;
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [DATA_W-1:0] w_data_q, rdata_q;
  logic [STRB_W-1:0] w_strb_q;
  logic [1:0] bresp_q, rresp_q;
  logic active_q;
  logic [LEVEL_W-1:0] tb_cnt_q, units_q;

  // ----------------------------------------------------------------
  // Register images
  // ----------------------------------------------------------------
  feature_csr_type colour_word, exposure_word;
  assign colour_word.level_hi = red_q;
  assign colour_word.level_lo = blue_q;
  assign colour_word.auto_mode = 1'b0;
  assign colour_word.active = COLOUR_VARIANT;
  assign colour_word.single_shot = 1'b0;
  assign colour_word.reserved = 3'h0;
  assign colour_word.abs_control = 1'b0;
  assign colour_word.present = COLOUR_VARIANT;
  assign exposure_word.level_hi = exp_q;
  assign exposure_word.level_lo = LEVEL_ZERO;
  assign exposure_word.auto_mode = 1'b0;
  assign exposure_word.active = 1'b1;
  assign exposure_word.single_shot = 1'b0;
  assign exposure_word.reserved = 3'h0;
  assign exposure_word.abs_control = 1'b0;
  assign exposure_word.present = 1'b1;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  // Address and data are parked separately so they may arrive in either order
  wire logic wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  wire reg_sel_type wr_sel = decode_sel(aw_addr_q);
  wire logic [DATA_W-1:0] colour_new = merge_bytes(colour_word, w_data_q, w_strb_q);
  wire logic [DATA_W-1:0] exposure_new = merge_bytes(exposure_word, w_data_q, w_strb_q);
  wire logic [LEVEL_W-1:0] blue_new = colour_new[LEVEL_LO_LSB +: LEVEL_W];
  wire logic [LEVEL_W-1:0] red_new = colour_new[LEVEL_HI_LSB +: LEVEL_W];
  wire logic [LEVEL_W-1:0] exp_new = exposure_new[LEVEL_HI_LSB +: LEVEL_W];
  wire logic colour_wr = wr_fire && (wr_sel == SEL_COLOUR) && COLOUR_VARIANT;
  wire logic exposure_wr = wr_fire && (wr_sel == SEL_EXPOSURE);

  // Out-of-range levels leave the held value untouched rather than clipping it
  assign blue_d = (colour_wr && level_ok(blue_new)) ? blue_new : blue_q;
  assign red_d = (colour_wr && level_ok(red_new)) ? red_new : red_q;
  assign exp_d = (exposure_wr && (exp_new >= EXPOSURE_MIN)) ? exp_new : exp_q;

  assign awready = !aw_hold_q && !bvalid_q;
  assign wready = !w_hold_q && !bvalid_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_hold_q <= 1'b1;
        aw_addr_q <= awaddr;
      end
      if (wvalid && wready) begin
        w_hold_q <= 1'b1;
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (wr_fire) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      blue_q <= COLOUR_VARIANT ? BLUE_DEFAULT : LEVEL_ZERO;
      red_q <= COLOUR_VARIANT ? RED_DEFAULT : LEVEL_ZERO;
      exp_q <= EXPOSURE_DEFAULT;
    end else begin
      blue_q <= blue_d;
      red_q <= red_d;
      exp_q <= exp_d;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  wire logic rd_fire = arvalid && arready;
  wire reg_sel_type rd_sel = decode_sel(araddr);
  wire logic [DATA_W-1:0] rd_word = (rd_sel == SEL_COLOUR) ? colour_word :
                                    (rd_sel == SEL_EXPOSURE) ? exposure_word : '0;

  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Exposure timer
  // ----------------------------------------------------------------
  // The count is latched at start, so a write during an exposure acts on the next one
  wire logic start_fire = exposure_start && !active_q;
  wire logic tb_wrap = (tb_cnt_q == LEVEL_ZERO);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_q <= 1'b0;
      tb_cnt_q <= LEVEL_ZERO;
      units_q <= LEVEL_ZERO;
    end else if (start_fire) begin
      active_q <= 1'b1;
      tb_cnt_q <= TIME_BASE_CYCLES - EXPOSURE_MIN;
      units_q <= exp_q;
    end else if (active_q) begin
      tb_cnt_q <= tb_wrap ? TIME_BASE_CYCLES - EXPOSURE_MIN : tb_cnt_q - EXPOSURE_MIN;
      if (tb_wrap) begin
        units_q <= units_q - EXPOSURE_MIN;
        active_q <= (units_q != EXPOSURE_MIN);
      end
    end
  end

  assign blue_level = blue_q;
  assign red_level = red_q;
  assign exposure_count = exp_q;
  assign exposure_active = active_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [EXP_LEN_W-1:0] elapsed_q, len_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      elapsed_q <= '0;
      len_q <= '0;
    end else if (start_fire) begin
      elapsed_q <= '0;
      len_q <= EXP_LEN_W'(exp_q) * TIME_BASE_CYCLES_WIDE;
    end else if (active_q) begin
      elapsed_q <= elapsed_q + EXP_LEN_W'(1);
    end
  end

  default clocking cb_clk @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence colour_read;
    rd_fire && (rd_sel == SEL_COLOUR);
  endsequence
  sequence exposure_read;
    rd_fire && (rd_sel == SEL_EXPOSURE);
  endsequence

  chk_colour_present: assert property (colour_read |=>
      rdata_q[PRESENT_BIT] == COLOUR_VARIANT && !rdata_q[ABS_CONTROL_BIT])
    else $error("colour presence or absolute flag wrong");
  chk_single_shot_zero: assert property ((colour_read or exposure_read) |=>
      !rdata_q[SINGLE_SHOT_BIT] && rdata_q[4:2] == 3'h0)
    else $error("single-shot or reserved bits not zero");
  chk_colour_active_manual: assert property (colour_read |=>
      rdata_q[ACTIVE_BIT] == COLOUR_VARIANT && !rdata_q[AUTO_MODE_BIT])
    else $error("colour active or mode flag wrong");
  chk_blue_range: assert property (colour_wr && !level_ok(blue_new) |=>
      $stable(blue_q))
    else $error("blue level took an out-of-range value");
  chk_red_range: assert property (colour_wr && !level_ok(red_new) |=>
      $stable(red_q))
    else $error("red level took an out-of-range value");
  chk_level_defaults: assert property ($past(!aresetn) |->
      blue_q == (COLOUR_VARIANT ? BLUE_DEFAULT : LEVEL_ZERO) &&
      red_q == (COLOUR_VARIANT ? RED_DEFAULT : LEVEL_ZERO))
    else $error("level defaults wrong after reset");
  chk_exposure_flags: assert property (exposure_read |=>
      rdata_q[7:0] == 8'h41 && rdata_q[LEVEL_HI_LSB-1:LEVEL_LO_LSB] == 12'h000)
    else $error("exposure flags or reserved field wrong");
  chk_exposure_count: assert property (exposure_read |=>
      rdata_q[DATA_W-1:LEVEL_HI_LSB] == $past(exp_q) && exp_q != LEVEL_ZERO)
    else $error("exposure count readback wrong");
  chk_exposure_length: assert property ($fell(active_q) |->
      elapsed_q == len_q)
    else $error("exposure length not count times time base");
  chk_write_answer: assert property (wr_fire |=> bvalid_q ##0
      (bresp_q == ((wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY)) [*1])
    else $error("write answer missing");

  // Writes that land, and starts that must be ignored
  chk_blue_update: assert property (colour_wr && level_ok(blue_new) |=>
      blue_q == $past(blue_new))
    else $error("blue level write lost");
  chk_red_update: assert property (colour_wr && level_ok(red_new) |=>
      red_q == $past(red_new))
    else $error("red level write lost");
  chk_count_nonzero: assert property (exposure_wr |=>
      exp_q != LEVEL_ZERO && (exp_q == $past(exp_new) || $stable(exp_q)))
    else $error("exposure count took zero");
  chk_start_refused: assert property (active_q && exposure_start && !tb_wrap |=>
      $stable(units_q) && active_q)
    else $error("start restarted a running exposure");

endmodule
`default_nettype wire

//--- colour_exposure_csr_test.sv
`default_nettype none
module colour_exposure_csr_test import colour_exposure_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  `define CHK(got, exp) \
    n_compared++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("ERROR %0t: got %h expected %h", $time, got, exp); \
    end

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] COL = 12'h80C;
  localparam logic [ADDR_W-1:0] EXP = 12'h81C;
  // Present and active set, every other flag clear
  localparam logic [7:0] FL = 8'h41;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, exposure_start;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [DATA_W-1:0] wdata, rdata, rdata_mono;
  logic [STRB_W-1:0] wstrb;
  logic awready, wready, bvalid, arready, rvalid, exposure_active;
  logic [1:0] bresp, rresp;
  logic [LEVEL_W-1:0] blue_level, red_level, exposure_count;
  int n_mismatch = 0;
  int n_compared = 0;

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  colour_exposure_csr dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .blue_level(blue_level), .red_level(red_level), .exposure_count(exposure_count),
    .exposure_start(exposure_start), .exposure_active(exposure_active));

  // Variant without colour balance, fed the same bus traffic
  colour_exposure_csr #(.COLOUR_VARIANT(1'b0)) dut_mono (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(), .bresp(), .bvalid(), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(), .rdata(rdata_mono), .rresp(), .rvalid(),
    .rready(rready), .blue_level(), .red_level(), .exposure_count(),
    .exposure_start(exposure_start), .exposure_active());

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
      input logic [STRB_W-1:0] s, input logic [1:0] er);
    bit pa, pw, ah, wh;
    logic [1:0] resp;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    // Ready only changes at rising edges, so the falling edge shows what the next edge takes
    while (pa || pw) begin
      @(negedge aclk);
      ah = pa && awready;
      wh = pw && wready;
      @(posedge aclk);
      if (ah) begin
        awvalid <= 1'b0;
        pa = 1'b0;
      end
      if (wh) begin
        wvalid <= 1'b0;
        pw = 1'b0;
      end
    end
    do begin
      @(negedge aclk);
    end while (!bvalid);
    resp = bresp;
    @(posedge aclk);
    bready <= 1'b0;
    `CHK(resp, er)
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e,
      input logic [DATA_W-1:0] em, input logic [1:0] er);
    bit h;
    logic [DATA_W-1:0] d, dm;
    logic [1:0] resp;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      h = arready;
      @(posedge aclk);
    end while (!h);
    arvalid <= 1'b0;
    do begin
      @(negedge aclk);
    end while (!rvalid);
    d = rdata;
    dm = rdata_mono;
    resp = rresp;
    @(posedge aclk);
    rready <= 1'b0;
    `CHK(d, e)
    `CHK(dm, em)
    `CHK(resp, er)
  endtask

  task automatic give_verdict;
    $display("Compared %0d, mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  // Colour rows: data, strobes, expected red and blue afterwards
  logic [31:0] cd[5] = '{32'h0FF040FF, 32'h01010000, 32'h00F0FF00, 32'hFFF08000, 32'h0000FF3E};
  logic [3:0] cs[5] = '{4'hF, 4'hF, 4'hF, 4'h2, 4'h1};
  logic [11:0] cr[5] = '{12'h0FF, 12'h010, 12'h010, 12'h010, 12'h010};
  logic [11:0] cb[5] = '{12'h040, 12'h040, 12'h0FF, 12'h080, 12'h080};
  // Exposure rows: written count with reserved bits set, expected count afterwards
  logic [11:0] ew[4] = '{12'h001, 12'h000, 12'hFFF, 12'h002};
  logic [11:0] ee[4] = '{12'h001, 12'h001, 12'hFFF, 12'h002};

  initial begin
    int n;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, exposure_start} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd(COL, {12'h068, 12'h059, FL}, 32'h0, RESP_OKAY);
    rd(EXP, {12'h1F4, 12'h000, FL}, {12'h1F4, 12'h000, FL}, RESP_OKAY);
    `CHK(blue_level, 12'h059)
    $display("test reset values done");
    for (int i = 0; i < 5; i++) begin
      wr(COL, cd[i], cs[i], RESP_OKAY);
      rd(COL, {cr[i], cb[i], FL}, 32'h0, RESP_OKAY);
      `CHK(red_level, cr[i])
      `CHK(blue_level, cb[i])
    end
    $display("test colour levels done");
    for (int i = 0; i < 4; i++) begin
      wr(EXP, {ew[i], 12'hFFF, 8'hFF}, 4'hF, RESP_OKAY);
      rd(EXP, {ee[i], 12'h000, FL}, {ee[i], 12'h000, FL}, RESP_OKAY);
      `CHK(exposure_count, ee[i])
    end
    $display("test exposure count done");
    wr(12'h810, 32'hFFFFFFFF, 4'hF, RESP_SLVERR);
    rd(12'h810, 32'h0, 32'h0, RESP_SLVERR);
    rd(COL, {12'h010, 12'h080, FL}, 32'h0, RESP_OKAY);
    $display("test unmapped done");
    // A second start in mid-exposure must not stretch it
    n = 0;
    @(posedge aclk);
    exposure_start <= 1'b1;
    while (n < 20000) begin
      @(posedge aclk);
      exposure_start <= (n == 100);
      @(negedge aclk);
      if (!exposure_active) break;
      n++;
    end
    `CHK(n, 5000)
    $display("test exposure time done");
    give_verdict();
  end

  initial begin
    repeat (40000) @(posedge aclk);
    n_mismatch++;
    give_verdict();
  end
endmodule
`default_nettype wire

//--- colour_exposure_pkg.sv
`default_nettype none
package colour_exposure_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int LEVEL_W = 12;
  localparam logic [ADDR_W-1:0] COLOUR_BALANCE_CONTROL_OFFSET = 12'h80C;
  localparam logic [ADDR_W-1:0] EXPOSURE_CONTROL_OFFSET = 12'h81C;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PRESENT_BIT = 0;
  localparam int ABS_CONTROL_BIT = 1;
  localparam int SINGLE_SHOT_BIT = 5;
  localparam int ACTIVE_BIT = 6;
  localparam int AUTO_MODE_BIT = 7;
  localparam int LEVEL_LO_LSB = 8;
  localparam int LEVEL_HI_LSB = 20;

  // ----------------------------------------------------------------
  // Values and limits
  // ----------------------------------------------------------------
  localparam logic [LEVEL_W-1:0] LEVEL_MIN = 12'h010;
  localparam logic [LEVEL_W-1:0] LEVEL_MAX = 12'h0FF;
  localparam logic [LEVEL_W-1:0] LEVEL_UNITY = 12'h040;
  localparam logic [LEVEL_W-1:0] BLUE_DEFAULT = 12'h059;
  localparam logic [LEVEL_W-1:0] RED_DEFAULT = 12'h068;
  localparam logic [LEVEL_W-1:0] EXPOSURE_MIN = 12'h001;
  localparam logic [LEVEL_W-1:0] EXPOSURE_DEFAULT = 12'h1F4;
  localparam logic [LEVEL_W-1:0] LEVEL_ZERO = 12'h000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int TIME_BASE_NS = 20000;
  localparam int TIME_BASE_CYCLES_INT = TIME_BASE_NS / CLK_PERIOD_NS;
  localparam int EXP_LEN_W = 24;
  localparam logic [LEVEL_W-1:0] TIME_BASE_CYCLES = LEVEL_W'(TIME_BASE_CYCLES_INT);
  localparam logic [EXP_LEN_W-1:0] TIME_BASE_CYCLES_WIDE = EXP_LEN_W'(TIME_BASE_CYCLES_INT);

  // ----------------------------------------------------------------
  // Bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SEL_NONE, SEL_COLOUR, SEL_EXPOSURE} reg_sel_type;

  // Layout shared by both feature registers
  typedef struct packed {
    logic [LEVEL_W-1:0] level_hi;
    logic [LEVEL_W-1:0] level_lo;
    logic auto_mode;
    logic active;
    logic single_shot;
    logic [2:0] reserved;
    logic abs_control;
    logic present;
  } feature_csr_type;

endpackage
`default_nettype wire
